// File: rtl/flic_pkg.sv
// shared constants for the four level interrupt controller
package flic_pkg;

  // ----------------------------------------------------------------
  // sources and levels
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 9;
  localparam int IDX_W = 4;
  localparam int LVL_W = 2;
  // source index doubles as the polling order within a level
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TIMER0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TIMER1 = 4'h3;
  localparam logic [3:0] SRC_SERIAL = 4'h4;
  localparam logic [3:0] SRC_TIMER2 = 4'h5;
  localparam logic [3:0] SRC_COUNTER_ARRAY = 4'h6;
  localparam logic [3:0] SRC_SPI = 4'h7;
  localparam logic [3:0] SRC_KBD = 4'h8;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_INTERRUPT_ENABLE = 10'h0a8;
  localparam logic [9:0] IDX_INTERRUPT_ENABLE1 = 10'h0a9;
  localparam logic [9:0] IDX_PRIORITY_HIGH = 10'h0b7;
  localparam logic [9:0] IDX_PRIORITY_LOW = 10'h0b8;
  localparam logic [9:0] IDX_PRIORITY_HIGH1 = 10'h0b6;
  localparam logic [9:0] IDX_PRIORITY_LOW1 = 10'h0b9;
  localparam logic [9:0] IDX_SERVICE_STATUS = 10'h0c0;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int STAT_INSERVICE_LSB = 0;
  localparam int STAT_PENDING_BIT = 4;
  localparam int STAT_VECTOR_LSB = 8;
  localparam int STAT_LEVEL_LSB = 12;
  localparam logic [7:0] INTERRUPT_ENABLE_RST = 8'h00;
  localparam logic [1:0] INTERRUPT_ENABLE1_RST = 2'h0;
  localparam logic [6:0] PRIORITY_RST = 7'h00;
  localparam logic [1:0] PRIORITY1_RST = 2'h0;
  localparam logic [3:0] INSERVICE_RST = 4'h0;

endpackage

// File: rtl/flic_arbiter.sv
// level then polling order selection among eligible requests
`timescale 1ns/1ps
module flic_arbiter
  import flic_pkg::*;
(
  input wire logic [NUM_SRC-1:0] eligible,
  input wire logic [2*NUM_SRC-1:0] srcLevel,
  output logic found,
  output logic [IDX_W-1:0] bestIdx,
  output logic [LVL_W-1:0] bestLevel
);

  // ----------------------------------------------------------------
  // scan from the last source down so a lower index wins a tie
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    bestIdx = '0;
    bestLevel = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!found || srcLevel[2*i +: 2] >= bestLevel)) begin
        found = 1'b1;
        bestIdx = IDX_W'(i);
        bestLevel = srcLevel[2*i +: 2];
      end
    end
  end

endmodule

// File: rtl/flic_controller.sv
// nine source four level interrupt controller with wishbone registers
//
// Summary of operation
// - nine request inputs: two pins, three timers, serial, spi, keyboard, counter array.
// - every source has its own enable bit.
// - enable bit 7 blocks all requests when zero.
// - each source takes one low and one high priority bit.
// - level equals high bit then low bit, 0 lowest, 3 highest.
// - a running routine is preempted only by a strictly higher level.
// - a level 3 routine is never preempted.
// - simultaneous requests of different levels: higher level served first.
// - equal levels resolved by fixed polling order, lowest index first.
// - enable bits 0..3: ext 0, timer 0, ext 1, timer 1.
// - enable bits 4..6: serial, timer 2, counter array.
// - enable register resets to zero.
// - low priority register bits 0..6 per source, bit 7 reserved.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module flic_controller
  import flic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] srcReq,
  output logic irqReq,
  output logic [IDX_W-1:0] irqVector,
  output logic [LVL_W-1:0] irqLevel,
  input wire logic irqAck,
  input wire logic irqReturn
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // highest level currently in service
  function automatic logic [LVL_W-1:0] topLevel(input logic [3:0] ins);
    logic [LVL_W-1:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      if (ins[k]) begin
        r = LVL_W'(k);
      end
    end
    return r;
  endfunction

  // register hit for an index
  function automatic logic hitIdx(input logic [11:0] adr, input logic [9:0] idx);
    return (adr[11:2] == idx);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] enable0_q;
  logic [1:0] enable1_q;
  logic [6:0] prioLow0_q;
  logic [6:0] prioHigh0_q;
  logic [1:0] prioLow1_q;
  logic [1:0] prioHigh1_q;
  logic [3:0] inService_q;
  logic [3:0] inService_d;
  logic irqReq_q;
  logic [IDX_W-1:0] irqVector_q;
  logic [LVL_W-1:0] irqLevel_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [NUM_SRC-1:0] allEnable;
  logic [NUM_SRC-1:0] prioLowAll;
  logic [NUM_SRC-1:0] prioHighAll;
  logic [2*NUM_SRC-1:0] srcLevel;
  logic [NUM_SRC-1:0] eligible;
  logic anyInService;
  logic [LVL_W-1:0] curLevel;
  logic found;
  logic [IDX_W-1:0] bestIdx;
  logic [LVL_W-1:0] bestLevel;
  logic busReq;
  logic wrByte;

  // ----------------------------------------------------------------
  // per-source gating and level
  // ----------------------------------------------------------------
  assign allEnable = {enable1_q, enable0_q[6:0]};
  assign prioLowAll = {prioLow1_q, prioLow0_q};
  assign prioHighAll = {prioHigh1_q, prioHigh0_q};
  assign anyInService = |inService_q;
  assign curLevel = topLevel(inService_q);

  // one slice per source: level code and eligibility
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gSrc
      assign srcLevel[2*g +: 2] = {prioHighAll[g], prioLowAll[g]};
      // strictly above the top in-service level; level 3 can never be exceeded
      assign eligible[g] = srcReq[g] && allEnable[g]
        && enable0_q[GLOBAL_IRQ_ENABLE_BIT]
        && (!anyInService || srcLevel[2*g +: 2] > curLevel);
    end
  endgenerate

  flic_arbiter flic_arbiter_inst (
    .eligible(eligible),
    .srcLevel(srcLevel),
    .found(found),
    .bestIdx(bestIdx),
    .bestLevel(bestLevel)
  );

  // ----------------------------------------------------------------
  // request to the core
  // ----------------------------------------------------------------
  // held low for a cycle around ack or return so the in-service
  // update lands before the next choice is offered
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqReq_q <= 1'b0;
      irqVector_q <= '0;
      irqLevel_q <= '0;
    end else begin
      irqReq_q <= found && !irqAck && !irqReturn;
      irqVector_q <= bestIdx;
      irqLevel_q <= bestLevel;
    end
  end

  assign irqReq = irqReq_q;
  assign irqVector = irqVector_q;
  assign irqLevel = irqLevel_q;

  // ----------------------------------------------------------------
  // in-service tracking
  // ----------------------------------------------------------------
  // return drops the top level first, so an ack in the same cycle wins
  always_comb begin
    inService_d = inService_q;
    if (irqReturn && anyInService) begin
      inService_d[curLevel] = 1'b0;
    end
    if (irqAck && irqReq_q) begin
      inService_d[irqLevel_q] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      inService_q <= INSERVICE_RST;
    end else begin
      inService_q <= inService_d;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: one wait state, writes on byte lane 0 only
  // ----------------------------------------------------------------
  assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
  // a write lands on the edge where the master sees ack, never before
  assign wrByte = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= busReq;
    end
  end

  assign wb_ack_o = ack_q;

  // enable registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable0_q <= INTERRUPT_ENABLE_RST;
      enable1_q <= INTERRUPT_ENABLE1_RST;
    end else if (wrByte) begin
      if (hitIdx(wb_adr_i, IDX_INTERRUPT_ENABLE)) begin
        enable0_q <= wb_dat_i[7:0];
      end
      if (hitIdx(wb_adr_i, IDX_INTERRUPT_ENABLE1)) begin
        enable1_q <= wb_dat_i[1:0];
      end
    end
  end

  // priority registers; reserved bits are not stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      prioLow0_q <= PRIORITY_RST;
      prioHigh0_q <= PRIORITY_RST;
      prioLow1_q <= PRIORITY1_RST;
      prioHigh1_q <= PRIORITY1_RST;
    end else if (wrByte) begin
      if (hitIdx(wb_adr_i, IDX_PRIORITY_LOW)) begin
        prioLow0_q <= wb_dat_i[6:0];
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_HIGH)) begin
        prioHigh0_q <= wb_dat_i[6:0];
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_LOW1)) begin
        prioLow1_q <= wb_dat_i[1:0];
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_HIGH1)) begin
        prioHigh1_q <= wb_dat_i[1:0];
      end
    end
  end

  // read mux; unmapped addresses read zero and still get ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (busReq) begin
      rdata_q <= '0;
      if (hitIdx(wb_adr_i, IDX_INTERRUPT_ENABLE)) begin
        rdata_q[7:0] <= enable0_q;
      end
      if (hitIdx(wb_adr_i, IDX_INTERRUPT_ENABLE1)) begin
        rdata_q[1:0] <= enable1_q;
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_LOW)) begin
        rdata_q[6:0] <= prioLow0_q;
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_HIGH)) begin
        rdata_q[6:0] <= prioHigh0_q;
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_LOW1)) begin
        rdata_q[1:0] <= prioLow1_q;
      end
      if (hitIdx(wb_adr_i, IDX_PRIORITY_HIGH1)) begin
        rdata_q[1:0] <= prioHigh1_q;
      end
      if (hitIdx(wb_adr_i, IDX_SERVICE_STATUS)) begin
        rdata_q[STAT_INSERVICE_LSB +: 4] <= inService_q;
        rdata_q[STAT_PENDING_BIT] <= irqReq_q;
        rdata_q[STAT_VECTOR_LSB +: IDX_W] <= irqVector_q;
        rdata_q[STAT_LEVEL_LSB +: LVL_W] <= irqLevel_q;
      end
    end
  end

  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] enPrev_q;
  logic [NUM_SRC-1:0] srcReqPrev_q;
  logic [NUM_SRC-1:0] prioLowPrev_q;
  logic [NUM_SRC-1:0] prioHighPrev_q;

  // previous-cycle enables, requests and priorities, read only by the checks
  always_ff @(posedge mclk) begin
    if (rst) begin
      enPrev_q <= '0;
      srcReqPrev_q <= '0;
      prioLowPrev_q <= '0;
      prioHighPrev_q <= '0;
    end else begin
      enPrev_q <= allEnable;
      srcReqPrev_q <= srcReq;
      prioLowPrev_q <= prioLowAll;
      prioHighPrev_q <= prioHighAll;
    end
  end

  a_global_gate: assert property (@(posedge mclk) disable iff (rst)
    !enable0_q[GLOBAL_IRQ_ENABLE_BIT] |=> !irqReq_q)
    else $error("request offered with global enable clear");

  a_source_enable: assert property (@(posedge mclk) disable iff (rst)
    irqReq_q |-> enPrev_q[irqVector_q])
    else $error("request offered for a disabled source");

  a_strict_preempt: assert property (@(posedge mclk) disable iff (rst)
    irqReq_q && anyInService |-> irqLevel_q > curLevel)
    else $error("request not above level in service");

  a_top_level_hold: assert property (@(posedge mclk) disable iff (rst)
    inService_q[3] |-> !irqReq_q)
    else $error("level 3 routine preempted");

  a_reset_clear: assert property (@(posedge mclk)
    rst |=> enable0_q == 8'h00 && inService_q == 4'h0)
    else $error("registers not cleared by reset");

  a_service_track: assert property (@(posedge mclk) disable iff (rst)
    irqAck && irqReq_q |=> inService_q[$past(irqLevel_q)] && !irqReq_q)
    else $error("acknowledged level not marked in service");

  a_return_release: assert property (@(posedge mclk) disable iff (rst)
    irqReturn && !irqAck && anyInService |=> !inService_q[$past(curLevel)])
    else $error("returned level not released");

  a_level_encode: assert property (@(posedge mclk) disable iff (rst)
    irqReq_q |-> irqLevel_q == {prioHighPrev_q[irqVector_q], prioLowPrev_q[irqVector_q]})
    else $error("level code does not follow high and low bits");

  a_req_pending: assert property (@(posedge mclk) disable iff (rst)
    irqReq_q |-> srcReqPrev_q[irqVector_q])
    else $error("request offered for a source not pending");

  a_prio_reserved: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o && hitIdx(wb_adr_i, IDX_PRIORITY_LOW) |-> !wb_dat_o[7])
    else $error("reserved priority bit reads one");

  a_return_mask: assert property (@(posedge mclk) disable iff (rst)
    irqReturn |=> !irqReq_q)
    else $error("request offered in the cycle after a return");

  a_reset_quiet: assert property (@(posedge mclk)
    rst |=> !irqReq_q && !wb_ack_o && allEnable == '0)
    else $error("outputs not quiet after reset");

  // ordering checks per source
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gChk
      a_level_order: assert property (@(posedge mclk) disable iff (rst)
        found && eligible[g] |-> srcLevel[2*g +: 2] <= bestLevel)
        else $error("lower level chosen over higher");

      a_poll_order: assert property (@(posedge mclk) disable iff (rst)
        found && eligible[g] && srcLevel[2*g +: 2] == bestLevel |-> bestIdx <= IDX_W'(g))
        else $error("polling order broken within level");
    end
  endgenerate

  c_vectored: cover property (@(posedge mclk) disable iff (rst)
    irqReq_q && irqAck);

  c_nested: cover property (@(posedge mclk) disable iff (rst)
    inService_q[0] && inService_q[2]);

  c_tie_break: cover property (@(posedge mclk) disable iff (rst)
    found && eligible[0] && eligible[1] && srcLevel[1:0] == srcLevel[3:2]);

  c_returned: cover property (@(posedge mclk) disable iff (rst)
    irqReturn && inService_q[3]);

  c_same_edge: cover property (@(posedge mclk) disable iff (rst)
    irqReq_q && irqAck && irqReturn);

endmodule

// File: testbench/flic_far_model.sv
// far side model: peripheral request flags and the core's vector fetch
`timescale 1ns/1ps
module flic_far_model
  import flic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] raise,
  input wire logic clearAll,
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  input wire logic irqReq,
  input wire logic [IDX_W-1:0] irqVector,
  input wire logic [LVL_W-1:0] irqLevel,
  output logic [NUM_SRC-1:0] srcReq,
  output logic irqAck,
  output logic [IDX_W-1:0] lastVec,
  output logic [LVL_W-1:0] lastLvl,
  output logic [7:0] takeCnt
);
  logic [3:0] waitQ;
  // a flag stays until its routine is entered, as a peripheral would hold it
  always_ff @(posedge mclk) begin
    if (rst || clearAll) begin
      srcReq <= '0;
    end else if (irqAck && irqReq) begin
      srcReq <= (srcReq | raise) & ~({{(NUM_SRC-1){1'b0}}, 1'b1} << irqVector);
    end else begin
      srcReq <= srcReq | raise;
    end
  end
  // record what the core took
  always_ff @(posedge mclk) begin
    if (rst) begin
      lastVec <= '0;
      lastLvl <= '0;
      takeCnt <= 8'h00;
    end else if (irqAck && irqReq) begin
      lastVec <= irqVector;
      lastLvl <= irqLevel;
      takeCnt <= takeCnt + 8'h01;
    end
  end
  // core fetch after ackDelay cycles; one-cycle pulse, never two in a row
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqAck <= 1'b0;
      waitQ <= 4'h0;
    end else if (irqReq && ackEn && !irqAck) begin
      if (waitQ == ackDelay) begin
        irqAck <= 1'b1;
        waitQ <= 4'h0;
      end else begin
        waitQ <= waitQ + 4'h1;
      end
    end else begin
      irqAck <= 1'b0;
      waitQ <= 4'h0;
    end
  end
endmodule

// File: testbench/four_level_interrupt_controller_bench.sv
// self-checking bench for the four level interrupt controller
`timescale 1ns/1ps
module four_level_interrupt_controller_bench
  import flic_pkg::*;
;
  typedef struct packed {
    logic [7:0] en;
    logic [1:0] en1;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [8:0] raise;
    logic [6:0] exp;
  } flic_case_s;
  localparam logic [11:0] A_EN = 12'h2a0, A_EN1 = 12'h2a4, A_LO = 12'h2e0, A_HI = 12'h2dc;
  localparam logic [11:0] A_STAT = 12'h300, A_NONE = 12'h3fc;
  localparam logic [11:0] A_LO1 = 12'h2e4, A_HI1 = 12'h2d8;
  logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, clearAll = 0, ackEn = 0;
  logic irqReturn = 0, wbAck, irqReq, irqAck;
  logic [11:0] wbAdr = 12'h000;
  logic [3:0] wbSel = 4'h0, ackDelay = 4'h0, irqVector;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic [8:0] raise = 9'h000, srcReq;
  logic [1:0] irqLevel, lastLvl;
  logic [3:0] lastVec;
  logic [7:0] takeCnt;
  logic [6:0] got;
  int errors = 0, samplesChecked = 0, cycles = 0;
  flic_case_s rows [16] = '{
    '{8'h81,2'h0,8'h00,8'h00,9'h001,7'h40}, '{8'h01,2'h0,8'h00,8'h00,9'h001,7'h00},
    '{8'h82,2'h0,8'h00,8'h00,9'h002,7'h44}, '{8'h84,2'h0,8'h00,8'h00,9'h004,7'h48},
    '{8'h88,2'h0,8'h00,8'h00,9'h008,7'h4c}, '{8'h90,2'h0,8'h00,8'h00,9'h010,7'h50},
    '{8'ha0,2'h0,8'h00,8'h00,9'h020,7'h54}, '{8'hc0,2'h0,8'h00,8'h00,9'h040,7'h58},
    '{8'h80,2'h3,8'h00,8'h00,9'h180,7'h5c}, '{8'h80,2'h2,8'h00,8'h00,9'h180,7'h60},
    '{8'hfe,2'h0,8'h00,8'h00,9'h003,7'h44}, '{8'hff,2'h0,8'h04,8'h00,9'h007,7'h49},
    '{8'hff,2'h0,8'h01,8'h02,9'h003,7'h46}, '{8'hff,2'h0,8'h08,8'h08,9'h04c,7'h4f},
    '{8'hff,2'h0,8'h00,8'h00,9'h050,7'h50}, '{8'h7f,2'h0,8'h00,8'h00,9'h07f,7'h00}};

  flic_controller flic_controller_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .srcReq(srcReq),
    .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel), .irqAck(irqAck),
    .irqReturn(irqReturn));
  flic_far_model flic_far_model_inst (.mclk(mclk), .rst(rst), .raise(raise),
    .clearAll(clearAll), .ackEn(ackEn), .ackDelay(ackDelay), .irqReq(irqReq),
    .irqVector(irqVector), .irqLevel(irqLevel), .srcReq(srcReq), .irqAck(irqAck),
    .lastVec(lastVec), .lastLvl(lastLvl), .takeCnt(takeCnt));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #12.5 mclk = ~mclk;
  // a stuck handshake must not hang the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatI <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wbDatO;
    wbCyc <= 0;
    wbStb <= 0;
    wbWe <= 0;
  endtask
  task automatic pulse(input logic [8:0] m, input logic ret);
    @(posedge mclk);
    raise <= m;
    irqReturn <= ret;
    @(posedge mclk);
    raise <= 9'h000;
    irqReturn <= 0;
  endtask
  task automatic settle(input int c, input logic [7:0] cnt, input logic [5:0] vl);
    repeat (c) @(posedge mclk);
    #1 check({lastVec, lastLvl, takeCnt}, {vl, cnt});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    wb(0, A_EN, 8'h00);
    check(rd, 32'h0);
    wb(1, A_LO, 8'hff);
    wb(0, A_LO, 8'h00);
    check(rd, 32'h7f);
    wb(1, A_HI, 8'hff);
    wb(0, A_HI, 8'h00);
    check(rd, 32'h7f);
    wb(1, A_EN1, 8'hff);
    wb(0, A_EN1, 8'h00);
    check(rd, 32'h3);
    wb(1, A_LO1, 8'hff);
    wb(0, A_LO1, 8'h00);
    check(rd, 32'h3);
    wb(1, A_HI1, 8'hff);
    wb(0, A_HI1, 8'h00);
    check(rd, 32'h3);
    // second bank back to level 0 so the rows see spi and keyboard at the bottom
    wb(1, A_LO1, 8'h00);
    wb(1, A_HI1, 8'h00);
    wb(1, A_NONE, 8'hff);
    wb(0, A_NONE, 8'h00);
    check(rd, 32'h0);
    $display("test registers done");
    // table rows with the core holding off its fetch
    foreach (rows[i]) begin
      wb(1, A_EN, rows[i].en);
      wb(1, A_EN1, {6'h0, rows[i].en1});
      wb(1, A_LO, rows[i].lo);
      wb(1, A_HI, rows[i].hi);
      pulse(rows[i].raise, 0);
      repeat (4) @(posedge mclk);
      #1 got = irqReq === 1'b1 ? {1'b1, irqVector, irqLevel} : {irqReq, 6'h0};
      check(got, rows[i].exp);
      @(posedge mclk);
      clearAll <= 1;
      @(posedge mclk);
      clearAll <= 0;
      $display("test row %0d done", i);
    end
    // nesting: src0 lvl1, src1 lvl2, src3 and src5 lvl3, src4 lvl0
    wb(1, A_EN, 8'hff);
    wb(1, A_EN1, 8'h00);
    wb(1, A_LO, 8'h29);
    wb(1, A_HI, 8'h2a);
    ackEn <= 1;
    pulse(9'h001, 0);
    settle(8, 8'h01, {4'h0, 2'h1});
    pulse(9'h010, 0);
    settle(8, 8'h01, {4'h0, 2'h1});
    ackDelay <= 4'h5;
    pulse(9'h002, 0);
    settle(20, 8'h02, {4'h1, 2'h2});
    pulse(9'h008, 0);
    settle(20, 8'h03, {4'h3, 2'h3});
    pulse(9'h020, 0);
    settle(20, 8'h03, {4'h3, 2'h3});
    wb(0, A_STAT, 8'h00);
    check(rd & 32'h1f, 32'h0e);
    pulse(9'h000, 1);
    settle(20, 8'h04, {4'h5, 2'h3});
    repeat (3) pulse(9'h000, 1);
    settle(20, 8'h05, {4'h4, 2'h0});
    wb(0, A_STAT, 8'h00);
    check(rd & 32'h3fff, 32'h0001);
    $display("test nesting done");
    // return and fetch on one edge: the fetched level must stay marked
    ackDelay <= 4'h0;
    pulse(9'h002, 0);
    do begin
      @(posedge mclk);
    end while (irqReq !== 1'b1);
    irqReturn <= 1;
    @(posedge mclk);
    irqReturn <= 0;
    settle(4, 8'h06, {4'h1, 2'h2});
    wb(0, A_STAT, 8'h00);
    check(rd & 32'h1f, 32'h04);
    $display("test same edge done");
    // reset in mid-run with a level in service and sources 0 to 6 enabled
    @(posedge mclk);
    rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    pulse(9'h1ff, 0);
    repeat (3) @(posedge mclk);
    #1 check({31'h0, irqReq}, 32'h0);
    wb(0, A_EN, 8'h00);
    check(rd, 32'h0);
    wb(0, A_STAT, 8'h00);
    check(rd, 32'h0);
    $display("test reset done");
    conclude();
  end
endmodule
